// >>> dv/lbp_host.sv
// Host model that issues register accesses.
`timescale 1ns/1ps
module lbp_host (
  input wire clk,
  output reg [7:0] reg_addr,
  output reg [15:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0;
  // Released lines show the inverse so stale values are never trusted.
  task acc(input w, input [7:0] a, input [15:0] d);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  end
  endtask
endmodule // lbp_host

// >>> dv/lbp_properties.sv
// Port assertions for the dimming block.
`timescale 1ns/1ps
module lbp_props (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire reg_rvalid,
  input wire pwm_step,
  input wire period_start,
  input wire [3:0] led_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RD_ANSWER:
    assert property (ce && reg_rd |=> reg_rvalid) else $error("read not answered");
  AST_UNMAPPED:
    assert property (ce && reg_rd && (reg_addr < 8'h29 || reg_addr > 8'h2C)
      |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  AST_WIDTH:
    assert property (reg_rvalid |-> reg_rdata[15:13] == 3'h0) else $error("upper bits set");
  AST_LED_MOVE:
    assert property ($changed(led_on) |-> $past(pwm_step) && $past(ce))
      else $error("led changed without step");
  AST_PSTART:
    assert property (period_start && $past(ce) |-> $past(pwm_step))
      else $error("period start without step");
  AST_FREEZE:
    assert property (!ce |=> $stable(led_on) && $stable(period_start) && $stable(reg_rvalid))
      else $error("state moved while enable low");
  AST_RD_PULSE:
    assert property (ce && !reg_rd |=> !reg_rvalid) else $error("read answer without read");
  cover property (period_start);
  cover property (!ce);
  cover property (reg_rvalid);
  cover property (led_on[1] && !led_on[0]);
endmodule // lbp_props
bind lbp_top lbp_props lbp_props_inst (.clk, .srst, .ce, .reg_addr, .reg_rd, .reg_rdata,
  .reg_rvalid, .pwm_step, .period_start, .led_on);

// >>> dv/testbench.sv
// Self-checking bench for the dimming block.
`timescale 1ns/1ps
module testbench;
  reg clk = 0;
  reg srst = 1;
  reg ce = 1;
  reg step = 0;
  wire [7:0] a;
  wire [15:0] wd, rdat;
  wire wr, rd, ps, rv;
  wire [3:0] led;
  integer mismatches = 0, check_count = 0, seed = 39217, i, j, k, n;
  reg [15:0] q[$];
  reg [15:0] ex [0:3];
  reg [15:0] cnt [0:3];
  reg [11:0] d, r;
  reg [3:0] hold;
  always #10 clk = ~clk;
  lbp_host lbp_host_inst (.clk(clk), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd));
  lbp_top lbp_top_inst (.clk(clk), .srst(srst), .ce(ce), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv), .pwm_step(step),
    .period_start(ps), .led_on(led));
  task chk(input [15:0] s, input [15:0] e);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  end
  endtask
  task rdx(input [7:0] ad, input [15:0] e);
  begin
    q.push_back(e);
    lbp_host_inst.acc(1'b0, ad, 16'h0000);
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  always @(negedge clk)
    if (rv !== 1'b0)
    begin
      if (q.size() == 0)
        chk({15'h0000, rv}, 16'h0000);
      else
        chk(rdat, q.pop_front());
    end
  initial
  begin
    #1000000;
    mismatches = mismatches + 1;
    summarize;
  end
  // ====
  // Main sequence: reset values, writes, then two counted periods.
  initial
  begin
    d = {$random(seed)} % 4094 + 1;
    r = $random(seed);
    repeat (2) @(negedge clk);
    srst = 0;
    step = 1;
    for (i = 0; i < 4; i = i + 1)
      rdx(8'h29 + i[7:0], 16'h0000);
    lbp_host_inst.acc(1'b1, 8'h2A, 16'h0FFF);
    lbp_host_inst.acc(1'b1, 8'h2B, {4'h0, d});
    lbp_host_inst.acc(1'b1, 8'h2C, {4'hF, r});
    lbp_host_inst.acc(1'b1, 8'h2D, 16'h1FFF);
    rdx(8'h2D, 16'h0000);
    rdx(8'h2C, {4'h1, r});
    rdx(8'h2B, {4'h0, d});
    ex[0] = 16'h0000;
    ex[1] = 16'h0FFF;
    ex[2] = {4'h0, d};
    ex[3] = 16'h0FFF;
    for (k = 0; k < 2; k = k + 1)
    begin
      i = 0;
      while (ps !== 1'b1 && i < 5000)
      begin
        @(negedge clk);
        i = i + 1;
      end
      chk({15'h0000, ps}, 16'h0001);
      // A write landing mid-period must wait for the next period.
      if (k == 0)
        fork
          lbp_host_inst.acc(1'b1, 8'h2B, 16'h0FFF);
        join_none
      for (j = 0; j < 4; j = j + 1)
        cnt[j] = 16'h0000;
      // Random idle cycles between steps; only steps advance the period.
      for (i = 0; i < 4095; i = i + 1)
      begin
        for (j = 0; j < 4; j = j + 1)
          cnt[j] = cnt[j] + led[j];
        n = {$random(seed)} % 2;
        if (n != 0)
        begin
          step = 1'b0;
          @(negedge clk);
          step = 1'b1;
        end
        @(negedge clk);
      end
      for (j = 0; j < 4; j = j + 1)
        chk(cnt[j], ex[j]);
      chk({15'h0000, ps}, 16'h0001);
      ex[2] = 16'h0FFF;
    end
    // Enable low: a write and a read are refused and all state holds.
    hold = led;
    ce = 1'b0;
    lbp_host_inst.acc(1'b1, 8'h29, 16'h0FFF);
    lbp_host_inst.acc(1'b0, 8'h2B, 16'h0000);
    chk({12'h000, led}, {12'h000, hold});
    chk({15'h0000, ps}, 16'h0001);
    ce = 1'b1;
    rdx(8'h29, 16'h0000);
    // Reset in mid-run returns every register and LED to zero.
    srst = 1'b1;
    repeat (2) @(negedge clk);
    chk({12'h000, led}, 16'h0000);
    srst = 1'b0;
    rdx(8'h2B, 16'h0000);
    @(negedge clk);
    chk(q.size(), 16'h0000);
    summarize;
  end
endmodule // testbench

// >>> hdl/lbp_chan.v
// One dimming channel: period-aligned shadow of its setting and the on/off decision.
`timescale 1ns/1ps
`include "lbp_defs.vh"

module lbp_chan (
  // Clock, reset, enable
  input wire clk,
  input wire srst,
  input wire ce,
  // Timebase from the parent
  input wire step,
  input wire [11:0] step_cnt,
  input wire period_start,
  // Configuration as written by software
  input wire [12:0] cfg,
  // LED conduction state
  output reg led_on
);

  reg [11:0] act_duty;
  reg act_dis;
  reg [11:0] next_duty;
  reg next_dis;

  // =====================================================================
  // Shadow update
  // Sampling only at the period boundary avoids a cut or doubled pulse.
  always @*
  begin
    next_duty = act_duty;
    next_dis = act_dis;
    if (period_start)
    begin
      next_duty = cfg[`LBP_DUTY_MSB:0];
      next_dis = cfg[`LBP_DIM_DIS_BIT];
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      act_duty <= `LBP_DUTY_OFF;
      act_dis <= 1'b0;
      led_on <= 1'b0;
    end
    else if (ce)
    begin
      act_duty <= next_duty;
      act_dis <= next_dis;
      if (step)
      begin
        if (next_dis)
          led_on <= 1'b1;
        else if (next_duty == `LBP_DUTY_FULL)
          led_on <= 1'b1;
        else
          led_on <= (step_cnt < next_duty);
      end
    end
  end

endmodule // lbp_chan

// >>> hdl/lbp_defs.vh
// Constants for the LED bypass dimming block, channels five to eight.
`ifndef LBP_DEFS_VH
`define LBP_DEFS_VH

// =====================================================================
// Register addresses
`define LBP_ADDR_LED5 8'h29
`define LBP_ADDR_LED6 8'h2A
`define LBP_ADDR_LED7 8'h2B
`define LBP_ADDR_LED8 8'h2C

// =====================================================================
// Field layout and reset value
`define LBP_DUTY_MSB 11
`define LBP_DIM_DIS_BIT 12
`define LBP_CFG_RESET 13'h0000
`define LBP_DUTY_OFF 12'h000
`define LBP_DUTY_FULL 12'hFFF

// =====================================================================
// Timebase: 4095 steps per period, counted 0 to 4094
`define LBP_STEP_LAST 12'hFFE
`define LBP_STEP_FIRST 12'h000

`endif

// >>> hdl/lbp_top.v
// Dimming configuration registers and PWM outputs for LED channels five to eight.
// Summary of operation
// - Four read/write registers at 0x29 to 0x2C, one per LED channel.
// - Bits 11:0 hold duty; zero keeps LED off, one gives 1/4095.
// - Duty all ones keeps LED on; other codes scale on-time linearly.
// - Bit 12 set disables dimming for that LED; clear enables dimming.
`timescale 1ns/1ps
`include "lbp_defs.vh"

module lbp_top (
  // Clock, reset, enable
  input wire clk,
  input wire srst,
  input wire ce,
  // Register port from the serial decoder
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg reg_rvalid,
  // PWM timebase step
  input wire pwm_step,
  // Period marker and LED states
  output reg period_start,
  output wire [3:0] led_on
);

  reg [12:0] cfg [0:3];
  reg [11:0] step_cnt;
  reg [11:0] next_step_cnt;
  reg [1:0] tb_state;
  reg [1:0] next_tb_state;
  reg next_pstart;
  reg [3:0] wr_en;
  reg [15:0] next_rdata;
  integer i;

  // =====================================================================
  // Timebase states, one-hot
  // The wait state makes the first step after reset open a period, so no
  // channel ever starts on a half-counted period.
  localparam [1:0] TB_WAIT = 2'h1;
  localparam [1:0] TB_RUN = 2'h2;

  // =====================================================================
  // Helpers
  // Address decode: bit 2 flags a mapped register, bits 1:0 pick it.
  function [2:0] lbp_decode;
    input [7:0] addr;
    begin
      case (addr)
        `LBP_ADDR_LED5: lbp_decode = 3'h4;
        `LBP_ADDR_LED6: lbp_decode = 3'h5;
        `LBP_ADDR_LED7: lbp_decode = 3'h6;
        `LBP_ADDR_LED8: lbp_decode = 3'h7;
        default: lbp_decode = 3'h0;
      endcase
    end
  endfunction

  // Read word: the three bits above the register always read as zero.
  function [15:0] lbp_read_word;
    input [12:0] value;
    begin
      lbp_read_word = {3'h0, value};
    end
  endfunction

  // Last step of a period: the 4095 steps are counted 0 to 4094.
  function lbp_last;
    input [11:0] cnt;
    begin
      lbp_last = (cnt == `LBP_STEP_LAST);
    end
  endfunction

  wire [2:0] wsel = lbp_decode(reg_addr);

  // =====================================================================
  // Named views of the four channel registers
  wire [12:0] led5_dimming_config = cfg[0];
  wire [12:0] led6_dimming_config = cfg[1];
  wire [12:0] led7_dimming_config = cfg[2];
  wire [12:0] led8_dimming_config = cfg[3];

  // =====================================================================
  // Register file
  // One enable per register, so a write can never reach a neighbour.
  always @*
  begin
    wr_en = 4'h0;
    if (reg_wr && wsel[2])
      wr_en[wsel[1:0]] = 1'b1;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      for (i = 0; i < 4; i = i + 1)
        cfg[i] <= `LBP_CFG_RESET;
    end
    else if (ce)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        if (wr_en[i])
          cfg[i] <= reg_wdata[`LBP_DIM_DIS_BIT:0];
      end
    end
  end

  // Unmapped addresses read as zero.
  always @*
  begin
    next_rdata = 16'h0000;
    case (wsel)
      3'h4: next_rdata = lbp_read_word(led5_dimming_config);
      3'h5: next_rdata = lbp_read_word(led6_dimming_config);
      3'h6: next_rdata = lbp_read_word(led7_dimming_config);
      3'h7: next_rdata = lbp_read_word(led8_dimming_config);
      default: next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // =====================================================================
  // Period timebase, 4095 steps per period
  // A period starts at the first step after reset and at each wrap.
  // A step offered while the enable is low is lost, not queued.
  always @*
  begin
    next_tb_state = tb_state;
    next_step_cnt = step_cnt;
    next_pstart = 1'b0;
    case (tb_state)
      TB_WAIT:
      begin
        if (pwm_step)
        begin
          next_tb_state = TB_RUN;
          next_step_cnt = `LBP_STEP_FIRST;
          next_pstart = 1'b1;
        end
      end
      TB_RUN:
      begin
        if (pwm_step)
        begin
          if (lbp_last(step_cnt))
          begin
            next_step_cnt = `LBP_STEP_FIRST;
            next_pstart = 1'b1;
          end
          else
            next_step_cnt = step_cnt + 12'h001;
        end
      end
      default:
      begin
        next_tb_state = TB_WAIT;
        next_step_cnt = `LBP_STEP_FIRST;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      tb_state <= TB_WAIT;
      step_cnt <= `LBP_STEP_FIRST;
      period_start <= 1'b0;
    end
    else if (ce)
    begin
      tb_state <= next_tb_state;
      step_cnt <= next_step_cnt;
      period_start <= next_pstart;
    end
  end

  // Channel logic sees the count it is about to act on.
  wire chan_start = next_pstart;
  wire [11:0] chan_cnt = next_step_cnt;

  // =====================================================================
  // Channels five to eight
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      lbp_chan u_chan (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .step(pwm_step),
        .step_cnt(chan_cnt),
        .period_start(chan_start),
        .cfg(cfg[g]),
        .led_on(led_on[g])
      );
    end
  endgenerate

endmodule // lbp_top
